// ===== rtl/plpd_top.sv
// Digital model of a PLL building block: oscillator output stage with
// divide-by-one/two and inhibit, plus a tri-state phase/frequency detector.
// Assumes clk stands in for the oscillator; all pins but srst are asynchronous.
//
// Behaviour
// - With divide select high the output toggles at half rate, else at full rate.
// - Oscillator inhibit high stops oscillation and clears the divider and the settling count.
// - While inhibited the oscillator output stays low.
// - The detector is edge-triggered and compares reference and feedback phase.
// - Detector inhibit high floats the detector output.
// - Detector inhibit high stops comparison; low lets detection run.
// - The two inhibits act independently of each other.
// - Oscillation is stable within 10 microseconds of being enabled.
`timescale 1ns/1ps
`include "plpd_map.svh"
module plpd_top (
  input  wire logic clk,              // System clock, 250 MHz
  input  wire logic srst,             // Synchronous reset, active high
  input  wire logic div_sel_in,       // Divide-by-two select pin
  input  wire logic osc_stop_in,      // Oscillator inhibit pin
  input  wire logic ref_in,           // Reference frequency pin
  input  wire logic fb_in,            // Feedback counter pin
  input  wire logic detector_stop_in, // Detector inhibit pin
  output logic      osc_out,          // Oscillator output
  output logic      osc_stable,       // High once oscillation has settled
  output logic      detector_out,     // Detector output level
  output logic      detector_out_oe   // Detector output enable
);
  localparam int STABLE_CYCLES = `PLPD_STABLE_CYCLES;
  localparam int STABLE_W      = $clog2(STABLE_CYCLES + 1);
  localparam int N_PINS        = 5;

  // Bit positions of the pins inside the synchroniser vector
  localparam int PIN_SEL      = 0;
  localparam int PIN_OSC_STOP = 1;
  localparam int PIN_DET_STOP = 2;
  localparam int PIN_REF      = 3;
  localparam int PIN_FB       = 4;

  // Both inhibits start asserted so nothing runs before the pins are seen
  localparam logic [N_PINS-1:0] SYNC_RESET = `PLPD_SYNC_RESET;

  // Pin levels and edge history
  logic [N_PINS-1:0]   pin_raw;
  logic [N_PINS-1:0]   pin_sync;
  logic [1:0]          edge_last;
  logic                sel_half;
  logic                osc_hold;
  logic                det_hold;

  // Oscillator section
  logic                phase;
  logic                half_en;
  logic                div_half;
  logic                next_osc_out;
  logic [STABLE_W-1:0] settle_cnt;
  logic                settle_done;

  // Detector pins
  logic                next_detector_out;
  logic                next_detector_out_oe;

  plpd_det_if det ();

  assign pin_raw[PIN_SEL]      = div_sel_in;
  assign pin_raw[PIN_OSC_STOP] = osc_stop_in;
  assign pin_raw[PIN_DET_STOP] = detector_stop_in;
  assign pin_raw[PIN_REF]      = ref_in;
  assign pin_raw[PIN_FB]       = fb_in;

  // Two flops per pin; only the second stage is read by any logic
  for (genvar i = 0; i < N_PINS; i++) begin : g_sync
    logic meta;
    logic level;

    always_ff @(posedge clk) begin
      if (srst) begin
        meta <= SYNC_RESET[i];
      end else begin
        meta <= pin_raw[i];
      end
    end

    always_ff @(posedge clk) begin
      if (srst) begin
        level <= SYNC_RESET[i];
      end else begin
        level <= meta;
      end
    end

    assign pin_sync[i] = level;
  end

  // Last settled level of the two frequency pins; reset to the idle low
  // level so that no false edge follows reset
  always_ff @(posedge clk) begin
    if (srst) begin
      edge_last <= `PLPD_EDGE_RESET;
    end else begin
      edge_last <= {pin_sync[PIN_FB], pin_sync[PIN_REF]};
    end
  end

  assign sel_half = pin_sync[PIN_SEL];
  assign osc_hold = srst | pin_sync[PIN_OSC_STOP];
  assign det_hold = pin_sync[PIN_DET_STOP];

  // Oscillator section, independent of the detector
  always_ff @(posedge clk) begin
    if (osc_hold) begin
      phase <= `PLPD_OSC_DIV_RESET;
    end else begin
      phase <= ~phase;
    end
  end

  // One-cycle enable on every second clock drives the half-rate stage
  assign half_en = phase;

  always_ff @(posedge clk) begin
    if (osc_hold) begin
      div_half <= `PLPD_OSC_DIV_RESET;
    end else if (half_en) begin
      div_half <= ~div_half;
    end
  end

  // Inhibit wins over the select; the pin parks low while stopped
  always_comb begin
    next_osc_out = 1'b0;
    if (!osc_hold) begin
      if (sel_half) begin
        next_osc_out = div_half;
      end else begin
        next_osc_out = ~phase;
      end
    end
  end

  always_ff @(posedge clk) begin
    osc_out <= next_osc_out;
  end

  assign settle_done = (settle_cnt == STABLE_W'(STABLE_CYCLES));

  // Restarts on every inhibit; saturates so a long run never wraps it
  always_ff @(posedge clk) begin
    if (osc_hold) begin
      settle_cnt <= '0;
    end else if (!settle_done) begin
      settle_cnt <= settle_cnt + STABLE_W'(1);
    end
  end

  // Counts from the synchronised pin, so it lags the pin by two clocks
  always_ff @(posedge clk) begin
    if (osc_hold) begin
      osc_stable <= 1'b0;
    end else if (settle_done) begin
      osc_stable <= 1'b1;
    end
  end

  assign det.ref_rise = pin_sync[PIN_REF] & ~edge_last[0];
  assign det.fb_rise  = pin_sync[PIN_FB] & ~edge_last[1];
  assign det.stop     = det_hold;

  // Pairing of edges lives in the state machine
  plpd_det_core u_core (
    .clk  (clk),
    .srst (srst),
    .det  (det.core)
  );

  // Floated while inhibited or aligned; level is parked low when floated
  always_comb begin
    next_detector_out    = 1'b0;
    next_detector_out_oe = 1'b0;
    if (!det_hold) begin
      case (det.state)
        plpd_pkg::PLPD_DET_UP: begin
          next_detector_out    = 1'b1;
          next_detector_out_oe = 1'b1;
        end
        plpd_pkg::PLPD_DET_DOWN: begin
          next_detector_out    = 1'b0;
          next_detector_out_oe = 1'b1;
        end
        plpd_pkg::PLPD_DET_FLOAT: begin
          next_detector_out    = 1'b0;
          next_detector_out_oe = 1'b0;
        end
        default: begin
          next_detector_out    = 1'b0;
          next_detector_out_oe = 1'b0;
        end
      endcase
    end
  end

  // Registered so the pins never glitch on a state change
  always_ff @(posedge clk) begin
    if (srst) begin
      detector_out <= 1'b0;
    end else begin
      detector_out <= next_detector_out;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      detector_out_oe <= 1'b0;
    end else begin
      detector_out_oe <= next_detector_out_oe;
    end
  end
endmodule : plpd_top

// ===== rtl/plpd_map.svh
// Timing constants for the phase detector and output divider block.
// Assumes inclusion from design files clocked at 250 MHz.
`ifndef PLPD_MAP_SVH
`define PLPD_MAP_SVH
`define PLPD_CLK_PERIOD_PS   32'd4000
`define PLPD_STABLE_TIME_NS  32'd10000
`define PLPD_STABLE_CYCLES   ((`PLPD_STABLE_TIME_NS * 32'd1000) / `PLPD_CLK_PERIOD_PS)
`define PLPD_OSC_DIV_RESET   1'b0
`define PLPD_SYNC_RESET      5'h06
`define PLPD_EDGE_RESET      2'h0
`endif

// ===== rtl/plpd_pkg.sv
// Types shared by the phase detector and output divider block.
// Assumes no other package is present.
package plpd_pkg;
  typedef enum logic [1:0] {
    PLPD_DET_FLOAT,
    PLPD_DET_UP,
    PLPD_DET_DOWN
  } plpd_det_e;
endpackage : plpd_pkg

// ===== rtl/plpd_det_if.sv
// Interface carrying the synchronised detector inputs and the detector state.
// Assumes one clock domain shared by both modports.
`timescale 1ns/1ps
interface plpd_det_if;
  logic               ref_rise;
  logic               fb_rise;
  logic               stop;
  plpd_pkg::plpd_det_e state;
  modport core (input ref_rise, input fb_rise, input stop, output state);
  modport top  (output ref_rise, output fb_rise, output stop, input state);
endinterface : plpd_det_if

// ===== rtl/plpd_det_core.sv
// Edge-triggered phase/frequency detector state machine.
// Assumes edge pulses already synchronised to clk.
`timescale 1ns/1ps
module plpd_det_core (
  input  wire logic   clk,   // System clock
  input  wire logic   srst,  // Synchronous reset
  plpd_det_if.core    det    // Edge pulses and detector state
);
  plpd_pkg::plpd_det_e next_state;

  always_comb begin
    next_state = det.state;
    if (det.stop) begin
      next_state = plpd_pkg::PLPD_DET_FLOAT;
    end else begin
      case (det.state)
        plpd_pkg::PLPD_DET_FLOAT: begin
          // Coincident edges mean aligned: stay floating
          if (det.ref_rise && !det.fb_rise) next_state = plpd_pkg::PLPD_DET_UP;
          else if (det.fb_rise && !det.ref_rise) next_state = plpd_pkg::PLPD_DET_DOWN;
        end
        plpd_pkg::PLPD_DET_UP: begin
          if (det.fb_rise) next_state = plpd_pkg::PLPD_DET_FLOAT;
        end
        plpd_pkg::PLPD_DET_DOWN: begin
          if (det.ref_rise) next_state = plpd_pkg::PLPD_DET_FLOAT;
        end
        default: next_state = plpd_pkg::PLPD_DET_FLOAT;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) det.state <= plpd_pkg::PLPD_DET_FLOAT;
    else      det.state <= next_state;
  end
endmodule : plpd_det_core

// ===== testbench/plpd_sva.sv
// Checker on the pins of plpd_top.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module plpd_sva (
  input wire logic clk,              // Clock
  input wire logic srst,             // Synchronous reset
  input wire logic div_sel_in,       // Divide select pin
  input wire logic osc_stop_in,      // Oscillator inhibit pin
  input wire logic ref_in,           // Reference pin
  input wire logic fb_in,            // Feedback pin
  input wire logic detector_stop_in, // Detector inhibit pin
  input wire logic osc_out,          // Oscillator output
  input wire logic osc_stable,       // Settled flag
  input wire logic detector_out,     // Detector level
  input wire logic detector_out_oe   // Detector enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  int run;
  always_ff @(posedge clk) run <= (srst || osc_stop_in) ? 0 : run + 1;
  sequence s_calm(x); (!x && !detector_stop_in)[*4]; endsequence
  property p_low; osc_stop_in[*4] |-> !osc_out && !osc_stable; endproperty
  property p_full; (!osc_stop_in && !div_sel_in)[*8] |-> osc_out != $past(osc_out); endproperty
  property p_half; (!osc_stop_in && div_sel_in)[*8] |-> osc_out != $past(osc_out, 2); endproperty
  property p_hiz; detector_stop_in[*5] |-> !detector_out_oe; endproperty
  property p_up; s_calm(fb_in) ##1 ($rose(ref_in) && !fb_in && !detector_out_oe)
    ##1 s_calm(fb_in) |-> detector_out_oe && detector_out; endproperty
  property p_dn; s_calm(ref_in) ##1 ($rose(fb_in) && !ref_in && !detector_out_oe)
    ##1 s_calm(ref_in) |-> detector_out_oe && !detector_out; endproperty
  property p_late; run >= 2510 |-> osc_stable; endproperty
  property p_early; $rose(osc_stable) |-> run >= 2500; endproperty
  a_low: assert property (p_low) else $error("osc not low");
  a_full: assert property (p_full) else $error("full rate");
  a_half: assert property (p_half) else $error("half rate");
  a_hiz: assert property (p_hiz) else $error("not floating");
  a_up: assert property (p_up) else $error("ref lead");
  a_dn: assert property (p_dn) else $error("fb lead");
  a_late: assert property (p_late) else $error("stable late");
  a_early: assert property (p_early) else $error("stable early");
endmodule : plpd_sva
bind plpd_top plpd_sva i_sva (
  .clk              (clk),
  .srst             (srst),
  .div_sel_in       (div_sel_in),
  .osc_stop_in      (osc_stop_in),
  .ref_in           (ref_in),
  .fb_in            (fb_in),
  .detector_stop_in (detector_stop_in),
  .osc_out          (osc_out),
  .osc_stable       (osc_stable),
  .detector_out     (detector_out),
  .detector_out_oe  (detector_out_oe)
);

// ===== testbench/plpd_fb_counter.sv
// Far-side counter: halves the rising edges of the oscillator output.
// Assumes osc is sampled on clk; hold clears it.
`timescale 1ns/1ps
module plpd_fb_counter (
  input  wire logic clk,  // Clock
  input  wire logic osc,  // Oscillator output
  input  wire logic hold, // Stall
  output logic      fb    // Counter output
);
  logic last = 0;
  // Plain divider, no clock recovery loop on this side
  always @(posedge clk) begin
    last <= osc;
    if (hold) fb <= #1 1'b0;
    else if (osc && !last) fb <= #1 !fb;
  end
endmodule : plpd_fb_counter

// ===== testbench/pll_phase_detector_divider_tb.sv
// Bench for plpd_top; pins change 1 ns after each edge.
// Assumes plpd_sva is bound and plpd_fb_counter is the far side.
`timescale 1ns/1ps
module pll_phase_detector_divider_tb;
  logic clk = 0, srst = 1, div_sel_in = 0, osc_stop_in = 1, ref_in = 0, fb_drv = 0, p;
  logic detector_stop_in = 1, hold = 1, use_fb = 0, fb_cnt, osc_out, osc_stable;
  logic detector_out, detector_out_oe;
  int n_errors = 0, samples_checked = 0, seed = 32'hf256, cyc = 0, st = 0, ch;
  wire fb_in = use_fb ? fb_cnt : fb_drv;
  plpd_top i_dut (
    .clk              (clk),
    .srst             (srst),
    .div_sel_in       (div_sel_in),
    .osc_stop_in      (osc_stop_in),
    .ref_in           (ref_in),
    .fb_in            (fb_in),
    .detector_stop_in (detector_stop_in),
    .osc_out          (osc_out),
    .osc_stable       (osc_stable),
    .detector_out     (detector_out),
    .detector_out_oe  (detector_out_oe)
  );
  plpd_fb_counter i_far (.clk, .osc(osc_out), .hold, .fb(fb_cnt));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc == 6000) begin n_errors++; tally_and_finish; end
  task tally_and_finish;
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task chk(string s, logic e, logic g);
    samples_checked++;
    if (g !== e) begin n_errors++; $display("BAD %s exp %b got %b", s, e, g); end
  endtask : chk
  task step(int n); repeat (n) @(posedge clk); #1; endtask : step
  task look;
    chk("oe", st != 0, detector_out_oe);
    if (st != 0) chk("out", st == 1, detector_out);
  endtask : look
  task pulse(int a); // 1 reference, 2 feedback
    if (a == 1) ref_in = 1; else fb_drv = 1;
    st = detector_stop_in ? 0 : (st == 0 || st == a) ? a : 0;
    step(3); ref_in = 0; fb_drv = 0; step(5); look;
  endtask : pulse
  initial begin
    step(8); srst = 0; osc_stop_in = 0; detector_stop_in = 0; step(8);
    for (int i = 0; i < 4; i++) begin
      div_sel_in = i[0]; step(6); ch = 0;
      repeat (8) begin p = osc_out; step(1); ch += int'(p ^ osc_out); end
      chk("rate", 1'b1, ch == (div_sel_in ? 4 : 8));
    end
    osc_stop_in = 1; step(4);
    chk("osc", 1'b0, osc_out); chk("stable", 1'b0, osc_stable);
    repeat (24) pulse(($random(seed) & 1) + 1);
    osc_stop_in = 0; detector_stop_in = 1; div_sel_in = 0; step(4);
    pulse(1); pulse(2);
    step(2500); chk("stable", 1'b1, osc_stable);
    detector_stop_in = 0; step(5); pulse(1);
    use_fb = 1; hold = 0; step(16); st = 2; look;
    hold = 1; step(4); use_fb = 0; tally_and_finish;
  end
endmodule : pll_phase_detector_divider_tb
